// File: hdl/smta_pkg.sv
// register map, field layout and state codes for the static and
// reserved-multicast table access block.
// assumes a 12-bit byte address on the register port, 32-bit data.
package smta_pkg;

    localparam int          ADDR_W        = 12;
    localparam int          DATA_W        = 32;

    // byte offsets of the register port
    localparam logic [11:0] OFS_CTRL      = 12'h41c;
    localparam logic [11:0] OFS_FLAGS     = 12'h420;
    localparam logic [11:0] OFS_PORTS     = 12'h424;
    localparam logic [11:0] OFS_FIDMAC    = 12'h428;
    localparam logic [11:0] OFS_MACLO     = 12'h42c;

    // control register fields
    localparam int          CTL_IDX_LSB   = 0;
    localparam int          CTL_IDX_W     = 6;
    localparam int          ST_IDX_W      = 4;
    localparam int          CTL_SEL_BIT   = 8;
    localparam int          CTL_ACT_BIT   = 9;
    localparam int          CTL_GO_BIT    = 31;
    localparam logic        SEL_STATIC    = 1'b0;
    localparam logic        SEL_MCAST     = 1'b1;
    localparam logic        ACT_WRITE     = 1'b0;
    localparam logic        ACT_READ      = 1'b1;

    // static_entry_flags fields
    localparam int          FL_VALID_BIT  = 31;
    localparam int          FL_SRCD_BIT   = 30;
    localparam int          FL_DSTD_BIT   = 29;
    localparam int          FL_PRI_LSB    = 26;
    localparam int          FL_PRI_W      = 3;
    localparam int          FL_STG_LSB    = 0;
    localparam int          FL_STG_W      = 3;

    // static_entry_ports fields
    localparam int          PT_OVR_BIT    = 31;
    localparam int          PT_USEF_BIT   = 30;
    localparam int          PT_MASK_W     = 7;

    // static_entry_fid_mac_high fields
    localparam int          FM_FID_LSB    = 16;
    localparam int          FM_FID_W      = 7;
    localparam int          FM_MACH_W     = 16;

    // writable bits of each entry register; the rest read zero
    localparam logic [31:0] FLAGS_MASK    = 32'hfc000007;
    localparam logic [31:0] PORTS_MASK    = 32'hc000007f;
    localparam logic [31:0] FIDMAC_MASK   = 32'h007fffff;
    localparam logic [31:0] MACLO_MASK    = 32'hffffffff;
    localparam logic [31:0] ENTRY_RESET   = 32'h00000000;

    // table geometry
    localparam int          ST_ENTRIES    = 16;
    localparam int          MC_ADDRS      = 48;
    localparam int          MC_GROUPS     = 8;
    localparam int          MC_GRP_W      = 3;
    localparam int          MC_PER_GROUP  = 6;

    typedef enum logic [1:0] {
        SMTA_IDLE = 2'b01,
        SMTA_EXEC = 2'b10
    } smta_state_t;

endpackage

// File: hdl/smta_table_access.sv
// indirect access to the 16-entry static address table and the
// 48-address reserved-multicast forwarding table, plus a lookup read port for each table.
// assumes host strobes and lookup index come from the i_clk_sys domain.
// Behaviour
// - table choice 0 selects static table
// - action 1 reads indexed entry
// - go bit launches, device clears when done
// - static read fills four entry registers
// - flags bit 31 is entry valid
// - bit 30 drops on source match
// - bit 29 drops on destination match
// - priority 28:26, spanning group 2:0
// - ports bit 31 enables port-state override
// - ports bit 30 uses filter id multicast
// - ports 6:0 egress mask, bit0 port1
// - filter id 22:16, mac high/low words
// - 48 multicast addresses, 6-bit index
// - write applies to whole fixed group
// - multicast uses same control and handshake
// - table choice 1 selects multicast table
// - action 0 writes registers into entry
// - multicast read returns mask in ports register
`timescale 1ns/1ns
`default_nettype none

module smta_table_access (
    // clock, reset, enable
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    // register port
    input  wire logic [11:0] i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    // lookup port, static table
    input  wire logic [3:0]  i_lk_idx,
    output logic             o_lk_valid,
    output logic             o_lk_src_drop,
    output logic             o_lk_dst_drop,
    output logic      [2:0]  o_lk_priority,
    output logic      [2:0]  o_lk_span_group,
    output logic             o_lk_override,
    output logic             o_lk_apply_filter_id_multicast_mc,
    output logic      [6:0]  o_lk_ports,
    output logic      [6:0]  o_lk_filter_id,
    output logic      [47:0] o_lk_mac,
    // lookup port, reserved multicast table
    input  wire logic [5:0]  i_mc_idx,
    output logic      [6:0]  o_mc_ports
);

    // fixed grouping: consecutive runs of six addresses share a mask
    function automatic logic [2:0] mc_group(input logic [5:0] idx);
        logic [5:0] q;
        q = idx / 6'(smta_pkg::MC_PER_GROUP);
        return q[2:0];
    endfunction

    function automatic logic mc_in_range(input logic [5:0] idx);
        return idx < 6'(smta_pkg::MC_ADDRS);
    endfunction

    smta_pkg::smta_state_t state_reg;

    logic [5:0]  idx_reg;
    logic        sel_reg;
    logic        act_reg;
    logic        go_reg;
    logic [31:0] flags_reg;
    logic [31:0] ports_reg;
    logic [31:0] fidmac_reg;
    logic [31:0] maclo_reg;

    logic [31:0] st_w0 [smta_pkg::ST_ENTRIES];
    logic [31:0] st_w1 [smta_pkg::ST_ENTRIES];
    logic [31:0] st_w2 [smta_pkg::ST_ENTRIES];
    logic [31:0] st_w3 [smta_pkg::ST_ENTRIES];
    logic [6:0]  mc_mask [smta_pkg::MC_GROUPS];

    logic        idle;
    logic        host_wr;
    logic        exec;
    logic [3:0]  st_idx;
    logic [2:0]  mc_grp;
    logic        mc_ok;
    logic        st_rd_op;
    logic        st_wr_op;
    logic        mc_rd_op;
    logic        mc_wr_op;
    logic [31:0] wr_masked;

    assign idle     = (state_reg == smta_pkg::SMTA_IDLE);
    assign exec     = i_ce && (state_reg == smta_pkg::SMTA_EXEC);
    // host writes while an operation runs are dropped, not queued
    assign host_wr  = i_ce && i_wr && idle;
    assign st_idx   = idx_reg[smta_pkg::ST_IDX_W-1:0];
    assign mc_grp   = mc_group(idx_reg);
    assign mc_ok    = mc_in_range(idx_reg);
    assign st_rd_op = exec && (sel_reg == smta_pkg::SEL_STATIC)
                      && (act_reg == smta_pkg::ACT_READ);
    assign st_wr_op = exec && (sel_reg == smta_pkg::SEL_STATIC)
                      && (act_reg == smta_pkg::ACT_WRITE);
    assign mc_rd_op = exec && (sel_reg == smta_pkg::SEL_MCAST)
                      && (act_reg == smta_pkg::ACT_READ);
    assign mc_wr_op = exec && (sel_reg == smta_pkg::SEL_MCAST)
                      && (act_reg == smta_pkg::ACT_WRITE);
    assign wr_masked = i_wdata;

    // control register
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            idx_reg <= 6'h00;
            sel_reg <= 1'b0;
            act_reg <= 1'b0;
            go_reg  <= 1'b0;
        end else if (host_wr && i_addr == smta_pkg::OFS_CTRL) begin
            idx_reg <= i_wdata[smta_pkg::CTL_IDX_LSB +: smta_pkg::CTL_IDX_W];
            sel_reg <= i_wdata[smta_pkg::CTL_SEL_BIT];
            act_reg <= i_wdata[smta_pkg::CTL_ACT_BIT];
            go_reg  <= i_wdata[smta_pkg::CTL_GO_BIT];
        end else if (exec) begin
            go_reg  <= 1'b0;
        end
    end

    // operation sequencer; every operation takes one cycle in exec
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= smta_pkg::SMTA_IDLE;
        end else if (i_ce) begin
            case (state_reg)
                smta_pkg::SMTA_IDLE: begin
                    if (host_wr && i_addr == smta_pkg::OFS_CTRL
                        && i_wdata[smta_pkg::CTL_GO_BIT]) begin
                        state_reg <= smta_pkg::SMTA_EXEC;
                    end
                end
                smta_pkg::SMTA_EXEC: begin
                    state_reg <= smta_pkg::SMTA_IDLE;
                end
                default: begin
                    state_reg <= smta_pkg::SMTA_IDLE;
                end
            endcase
        end
    end

    // entry data registers; reserved bits are masked on every host write
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flags_reg  <= smta_pkg::ENTRY_RESET;
            ports_reg  <= smta_pkg::ENTRY_RESET;
            fidmac_reg <= smta_pkg::ENTRY_RESET;
            maclo_reg  <= smta_pkg::ENTRY_RESET;
        end else if (st_rd_op) begin
            flags_reg  <= st_w0[st_idx];
            ports_reg  <= st_w1[st_idx];
            fidmac_reg <= st_w2[st_idx];
            maclo_reg  <= st_w3[st_idx];
        end else if (mc_rd_op) begin
            // upper flag bits are left as the host wrote them
            ports_reg[smta_pkg::PT_MASK_W-1:0] <=
                mc_ok ? mc_mask[mc_grp] : 7'h00;
        end else if (host_wr) begin
            case (i_addr)
                smta_pkg::OFS_FLAGS:
                    flags_reg  <= wr_masked & smta_pkg::FLAGS_MASK;
                smta_pkg::OFS_PORTS:
                    ports_reg  <= wr_masked & smta_pkg::PORTS_MASK;
                smta_pkg::OFS_FIDMAC:
                    fidmac_reg <= wr_masked & smta_pkg::FIDMAC_MASK;
                smta_pkg::OFS_MACLO:
                    maclo_reg  <= wr_masked & smta_pkg::MACLO_MASK;
                default: begin
                end
            endcase
        end
    end

    // static table storage
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < smta_pkg::ST_ENTRIES; i++) begin
                st_w0[i] <= smta_pkg::ENTRY_RESET;
                st_w1[i] <= smta_pkg::ENTRY_RESET;
                st_w2[i] <= smta_pkg::ENTRY_RESET;
                st_w3[i] <= smta_pkg::ENTRY_RESET;
            end
        end else if (st_wr_op) begin
            st_w0[st_idx] <= flags_reg;
            st_w1[st_idx] <= ports_reg;
            st_w2[st_idx] <= fidmac_reg;
            st_w3[st_idx] <= maclo_reg;
        end
    end

    // reserved-multicast storage, one mask per group
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int g = 0; g < smta_pkg::MC_GROUPS; g++) begin
                mc_mask[g] <= 7'h00;
            end
        end else if (mc_wr_op && mc_ok) begin
            mc_mask[mc_grp] <= ports_reg[smta_pkg::PT_MASK_W-1:0];
        end
    end

    // register read port; unmapped offsets read zero
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 32'h00000000;
        end else if (i_ce && i_rd) begin
            case (i_addr)
                smta_pkg::OFS_CTRL: begin
                    o_rdata <= 32'h00000000;
                    o_rdata[smta_pkg::CTL_IDX_LSB +: smta_pkg::CTL_IDX_W] <= idx_reg;
                    o_rdata[smta_pkg::CTL_SEL_BIT] <= sel_reg;
                    o_rdata[smta_pkg::CTL_ACT_BIT] <= act_reg;
                    o_rdata[smta_pkg::CTL_GO_BIT]  <= go_reg;
                end
                smta_pkg::OFS_FLAGS:  o_rdata <= flags_reg;
                smta_pkg::OFS_PORTS:  o_rdata <= ports_reg;
                smta_pkg::OFS_FIDMAC: o_rdata <= fidmac_reg;
                smta_pkg::OFS_MACLO:  o_rdata <= maclo_reg;
                default:              o_rdata <= 32'h00000000;
            endcase
        end
    end

    // lookup port, one cycle after the index
    logic [31:0] lk_w0;
    logic [31:0] lk_w1;
    logic [31:0] lk_w2;
    assign lk_w0 = st_w0[i_lk_idx];
    assign lk_w1 = st_w1[i_lk_idx];
    assign lk_w2 = st_w2[i_lk_idx];

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_lk_valid      <= 1'b0;
            o_lk_src_drop   <= 1'b0;
            o_lk_dst_drop   <= 1'b0;
            o_lk_priority   <= 3'h0;
            o_lk_span_group <= 3'h0;
            o_lk_override   <= 1'b0;
            o_lk_apply_filter_id_multicast_mc <= 1'b0;
            o_lk_ports      <= 7'h00;
            o_lk_filter_id  <= 7'h00;
            o_lk_mac        <= 48'h000000000000;
            o_mc_ports      <= 7'h00;
        end else if (i_ce) begin
            o_lk_valid      <= lk_w0[smta_pkg::FL_VALID_BIT];
            o_lk_src_drop   <= lk_w0[smta_pkg::FL_SRCD_BIT];
            o_lk_dst_drop   <= lk_w0[smta_pkg::FL_DSTD_BIT];
            o_lk_priority   <= lk_w0[smta_pkg::FL_PRI_LSB +: smta_pkg::FL_PRI_W];
            o_lk_span_group <= lk_w0[smta_pkg::FL_STG_LSB +: smta_pkg::FL_STG_W];
            o_lk_override   <= lk_w1[smta_pkg::PT_OVR_BIT];
            o_lk_apply_filter_id_multicast_mc <= lk_w1[smta_pkg::PT_USEF_BIT];
            o_lk_ports      <= lk_w1[smta_pkg::PT_MASK_W-1:0];
            o_lk_filter_id  <= lk_w2[smta_pkg::FM_FID_LSB +: smta_pkg::FM_FID_W];
            o_lk_mac        <= {lk_w2[smta_pkg::FM_MACH_W-1:0], st_w3[i_lk_idx]};
            o_mc_ports      <= mc_in_range(i_mc_idx)
                               ? mc_mask[mc_group(i_mc_idx)] : 7'h00;
        end
    end

    // checks
    logic [31:0] rd_w0;
    logic [6:0]  mc_cur;
    assign rd_w0  = st_w0[st_idx];
    assign mc_cur = mc_mask[mc_grp];

    go_launch_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        host_wr && i_addr == smta_pkg::OFS_CTRL && i_wdata[smta_pkg::CTL_GO_BIT]
        |=> go_reg && state_reg == smta_pkg::SMTA_EXEC)
        else $error("go write did not launch an operation");

    go_done_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        exec |=> !go_reg && state_reg == smta_pkg::SMTA_IDLE)
        else $error("go bit not cleared after the operation");

    static_read_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        st_rd_op |=> flags_reg == $past(rd_w0))
        else $error("static read did not load the flags word");

    mc_read_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        mc_rd_op && mc_ok |=> ports_reg[6:0] == $past(mc_cur))
        else $error("multicast read did not return the group mask");

    mc_group_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        mc_wr_op && mc_ok |=> mc_mask[$past(mc_grp)] == $past(ports_reg[6:0]))
        else $error("multicast write did not update the group");

    static_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        st_wr_op |=> st_w3[$past(st_idx)] == $past(maclo_reg))
        else $error("static write did not store the address word");

    rsv_zero_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (flags_reg & ~smta_pkg::FLAGS_MASK) == 32'h00000000
        && (ports_reg & ~smta_pkg::PORTS_MASK) == 32'h00000000
        && (fidmac_reg & ~smta_pkg::FIDMAC_MASK) == 32'h00000000)
        else $error("reserved entry bits not zero");

    busy_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        exec && i_wr && i_addr == smta_pkg::OFS_MACLO && !st_rd_op
        |=> maclo_reg == $past(maclo_reg))
        else $error("entry register changed by a write while busy");

    lk_drop_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_ce |=> o_lk_dst_drop == $past(lk_w0[29]) && o_lk_src_drop == $past(lk_w0[30]))
        else $error("lookup drop flags do not follow the entry");

endmodule

`default_nettype wire

// File: dv/smta_table_access_tb.sv
// self-checking bench for the static and reserved-multicast table access block.
// assumes one clock; the host port is driven by non-blocking updates at rising edges.
`timescale 1ns/1ns
`default_nettype none

module smta_table_access_tb;
    logic        i_clk_sys, i_rst_n, i_ce, i_wr, i_rd;
    logic [11:0] i_addr;
    logic [31:0] i_wdata, o_rdata, seed;
    logic [3:0]  i_lk_idx;
    logic [5:0]  i_mc_idx;
    logic        o_lk_valid, o_lk_src_drop, o_lk_dst_drop, o_lk_override, o_lk_apply_filter_id_multicast_mc;
    logic [2:0]  o_lk_priority, o_lk_span_group;
    logic [6:0]  o_lk_ports, o_lk_filter_id, o_mc_ports;
    logic [47:0] o_lk_mac;
    logic [31:0] st [16][4];
    logic [31:0] er [4];
    logic [31:0] mk [4];
    logic [6:0]  mcm [8];
    logic [31:0] qe [$];
    string       qn [$];
    logic        rd_pend;
    int          failures, cmp_count;

    smta_table_access dut (
        .i_clk_sys       (i_clk_sys),
        .i_rst_n         (i_rst_n),
        .i_ce            (i_ce),
        .i_addr          (i_addr),
        .i_wdata         (i_wdata),
        .i_wr            (i_wr),
        .i_rd            (i_rd),
        .o_rdata         (o_rdata),
        .i_lk_idx        (i_lk_idx),
        .o_lk_valid      (o_lk_valid),
        .o_lk_src_drop   (o_lk_src_drop),
        .o_lk_dst_drop   (o_lk_dst_drop),
        .o_lk_priority   (o_lk_priority),
        .o_lk_span_group (o_lk_span_group),
        .o_lk_override   (o_lk_override),
        .o_lk_apply_filter_id_multicast_mc (o_lk_apply_filter_id_multicast_mc),
        .o_lk_ports      (o_lk_ports),
        .o_lk_filter_id  (o_lk_filter_id),
        .o_lk_mac        (o_lk_mac),
        .i_mc_idx        (i_mc_idx),
        .o_mc_ports      (o_mc_ports)
    );

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] ctl(input logic go, act, sel, input logic [5:0] idx);
        return {go, 21'h000000, act, sel, 2'h0, idx};
    endfunction

    function automatic logic [11:0] ofs(input int k);
        return smta_pkg::OFS_FLAGS + 12'(4 * k);
    endfunction

    task automatic check(input string nm, input logic [79:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (failures == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // one bus cycle per call, so consecutive calls give back-to-back strobes
    task automatic bus(input logic w, r, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_wr    <= w;
        i_rd    <= r;
        i_addr  <= a;
        i_wdata <= d;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, 1'b1, a, 32'h00000000);
        qe.push_back(e);
        qn.push_back(nm);
    endtask

    task automatic wr_entry(input int k, input logic [31:0] d);
        wr(ofs(k), d);
        er[k] = d & mk[k];
    endtask

    // launch, check go in the busy cycle (or try a dropped write), then done
    task automatic op(input logic sel, act, input logic [5:0] idx, input logic busy_wr);
        wr(smta_pkg::OFS_CTRL, ctl(1'b1, act, sel, idx));
        if (busy_wr) wr(smta_pkg::OFS_MACLO, 32'hffffffff);
        else rd(smta_pkg::OFS_CTRL, ctl(1'b1, act, sel, idx), "go busy");
        rd(smta_pkg::OFS_CTRL, ctl(1'b0, act, sel, idx), "go done");
        if (sel == smta_pkg::SEL_STATIC && act == smta_pkg::ACT_WRITE) st[idx[3:0]] = er;
        if (sel == smta_pkg::SEL_STATIC && act == smta_pkg::ACT_READ) er = st[idx[3:0]];
        if (sel == smta_pkg::SEL_MCAST && act == smta_pkg::ACT_WRITE && idx < 48)
            mcm[idx / 6] = er[1][6:0];
        if (sel == smta_pkg::SEL_MCAST && act == smta_pkg::ACT_READ)
            er[1][6:0] = (idx < 48) ? mcm[idx / 6] : 7'h00;
    endtask

    // read data appear in the cycle after the strobe and hold until the next read
    always @(posedge i_clk_sys) begin
        if (rd_pend) begin
            if (qe.size() == 0) failures++;
            else check(qn.pop_front(), 80'(o_rdata), 80'(qe.pop_front()));
        end
        rd_pend <= i_rd & i_ce & i_rst_n;
    end

    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    initial begin
        repeat (60000) @(posedge i_clk_sys);
        failures++;
        wrap_up();
    end

    initial begin
        seed = 32'h0462f1ee;
        {i_rst_n, i_wr, i_rd, i_addr, i_wdata, i_lk_idx, i_mc_idx, rd_pend} = '0;
        i_ce = 1'b1;
        mk = '{smta_pkg::FLAGS_MASK, smta_pkg::PORTS_MASK, smta_pkg::FIDMAC_MASK,
               smta_pkg::MACLO_MASK};
        for (int k = 0; k < 16; k++) st[k] = '{default: 32'h00000000};
        er = '{default: 32'h00000000};
        mcm = '{default: 7'h00};
        repeat (4) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        for (int k = 0; k < 4; k++) rd(ofs(k), 32'h00000000, "entry reset");
        rd(smta_pkg::OFS_CTRL, 32'h00000000, "ctrl reset");
        rd(12'h000, 32'h00000000, "unmapped");
        // static writes with random data; reserved bits must vanish
        for (int i = 0; i < 16; i++) begin
            for (int k = 0; k < 4; k++) wr_entry(k, rnd());
            for (int k = 0; k < 4; k++) rd(ofs(k), er[k], "entry reg");
            op(smta_pkg::SEL_STATIC, smta_pkg::ACT_WRITE, 6'(i), i == 3);
            rd(smta_pkg::OFS_MACLO, er[3], "busy write dropped");
        end
        for (int k = 0; k < 4; k++) wr_entry(k, rnd());
        for (int i = 15; i >= 0; i--) begin
            op(smta_pkg::SEL_STATIC, smta_pkg::ACT_READ, 6'(i), 1'b0);
            for (int k = 0; k < 4; k++) rd(ofs(k), er[k], "static read");
        end
        // multicast: one write per group, then an out-of-range write ignored
        for (int g = 0; g < 8; g++) begin
            wr_entry(1, rnd());
            op(smta_pkg::SEL_MCAST, smta_pkg::ACT_WRITE, 6'(g * 6 + rnd() % 6), 1'b0);
        end
        wr_entry(1, rnd());
        op(smta_pkg::SEL_MCAST, smta_pkg::ACT_WRITE, 6'd50, 1'b0);
        for (int i = 0; i < 64; i++) begin
            op(smta_pkg::SEL_MCAST, smta_pkg::ACT_READ, 6'(i), 1'b0);
            rd(smta_pkg::OFS_PORTS, er[1], "mcast read");
        end
        // clock enable low: the write must not land
        @(posedge i_clk_sys);
        {i_ce, i_wr, i_rd} <= 3'b010;
        i_addr <= smta_pkg::OFS_MACLO;
        i_wdata <= ~er[3];
        @(posedge i_clk_sys);
        {i_ce, i_wr} <= 2'b10;
        rd(smta_pkg::OFS_MACLO, er[3], "ce freeze");
        bus(1'b0, 1'b0, 12'h000, 32'h00000000);
        // lookup ports follow the tables one cycle after the index
        for (int i = 0; i < 64; i++) begin
            @(posedge i_clk_sys);
            i_lk_idx <= 4'(i);
            i_mc_idx <= 6'(i);
            @(posedge i_clk_sys);
            #1;
            check("lookup static", {o_lk_valid, o_lk_src_drop, o_lk_dst_drop, o_lk_priority,
                  o_lk_span_group, o_lk_override, o_lk_apply_filter_id_multicast_mc, o_lk_ports, o_lk_filter_id,
                  o_lk_mac}, {st[i % 16][0][31:26], st[i % 16][0][2:0], st[i % 16][1][31:30],
                  st[i % 16][1][6:0], st[i % 16][2][22:0],
                  st[i % 16][3]});
            check("lookup mcast", 80'(o_mc_ports), 80'((i < 48) ? mcm[i / 6] : 7'h00));
        end
        repeat (3) @(posedge i_clk_sys);
        if (qe.size() != 0) failures++;
        wrap_up();
    end
endmodule

`default_nettype wire
